// ==== rtl/bus_status_pkg.sv ====
package bus_status_pkg;

	// cycle status codes, bits 2..0
	localparam logic [2:0] CYC_INTA = 3'h0;
	localparam logic [2:0] CYC_IO_RD = 3'h1;
	localparam logic [2:0] CYC_IO_WR = 3'h2;
	localparam logic [2:0] CYC_HALT = 3'h3;
	localparam logic [2:0] CYC_FETCH = 3'h4;
	localparam logic [2:0] CYC_MEM_RD = 3'h5;
	localparam logic [2:0] CYC_MEM_WR = 3'h6;
	localparam logic [2:0] CYC_PASSIVE = 3'h7;

	localparam logic [19:0] RESET_ADDR = 20'hffff0;

	// reset timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int RESET_MIN_US = 1000;
	localparam int RESET_MIN_CYC = (RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int STABLE_CLK_PERIODS = 4;
	// 6.5 periods after release, rounded up
	localparam int FETCH_DELAY_HALF = 13;
	localparam int FETCH_DELAY_CYC = (FETCH_DELAY_HALF + 1) / 2;

	typedef enum logic [2:0] {
		T_IDLE = 3'h0,
		T_ADDR = 3'h1,
		T_TURN = 3'h3,
		T_DATA = 3'h2,
		T_END = 3'h6
	} bus_phase_t;

endpackage

// ==== rtl/reset_sync.sv ====
`timescale 1ns/1ns
module reset_sync (
	input wire logic i_ref_clk,
	input wire logic i_clk_en,
	input wire logic i_raw_n,
	output logic o_sync_n
);
	logic [1:0] stage;

	// async assert, sync release; stage[0] only feeds stage[1]
	always_ff @(posedge i_ref_clk or negedge i_raw_n) begin
		if (!i_raw_n) begin
			stage <= 2'h0;
		end else if (i_clk_en) begin
			// frozen with the rest of the block while enable is low
			stage <= {stage[0], 1'b1};
		end
	end

	assign o_sync_n = stage[1];
endmodule

// ==== rtl/bus_status_reset.sv ====
`timescale 1ns/1ns
// What this block does
// [R1] read strobe waits until bus floated
// [R2] read strobe floats during bus hold
// [R3] reset aborts, clears, vectors to ffff0h
// [R4] reset source holds reset 1 ms
// [R5] reset synchronised before use
// [R6] clock stable four periods during reset
// [R7] first fetch 6.5 clocks after release
// [R8] refresh strobe low for dram refresh
// [R9] strap high: skip bit suppresses address
// [R10] strap low: address always on bus
// [R11] address strap caught one clock after release
// [R12] refresh/strap pin floats in hold, test
// [R13] three status bits encode cycle type
// [R14] status bits float during hold
// [R15] dma flag high t2-t4, floats hold/reset
// [R16] half clock strap low: divide by two
// [R17] pin driver must not pull low in reset
// [R18] strap low returns emulator pins normal
// [R19] straps held until next reset
// [R20] both test pins low floats all
module bus_status_reset
	import bus_status_pkg::*;
#(
	parameter int RESET_FILTER_CYC = RESET_MIN_CYC
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_addr_bus_strap,
	input wire logic i_half_clock_strap,
	input wire logic i_float_test0_n,
	input wire logic i_float_test1_n,
	input wire logic i_hold_req,
	input wire logic i_cycle_start,
	input wire logic [2:0] i_cycle_type,
	input wire logic i_cycle_dma,
	input wire logic i_cycle_refresh,
	input wire logic i_cycle_upper_sel,
	input wire logic i_cycle_lower_sel,
	input wire logic i_psram_mode,
	input wire logic i_up_skip_addr_phase_bit,
	input wire logic i_low_skip_addr_phase_bit,
	output logic o_system_clock_out,
	output logic o_fetch_start,
	output logic [19:0] o_fetch_addr,
	output logic o_hold_ack,
	output logic [2:0] o_cycle_status,
	output logic o_cycle_status_oe_n,
	output logic o_read_strobe_n,
	output logic o_read_strobe_oe_n,
	output logic o_mux_addr_phase,
	output logic o_muxed_addr_data_oe_n,
	output logic o_refresh_strobe_n,
	output logic o_refresh_strobe_oe_n,
	output logic o_dma_cycle_flag,
	output logic o_dma_cycle_flag_oe_n,
	output logic o_emulator_pins_normal,
	output logic o_float_all_test_mode,
	output logic o_half_clock_mode,
	output logic o_addr_phase_enabled
);

	////////////////////////////////////////////////////////////////////////
	// input synchronisers

	logic rst_sync_n;
	logic [1:0] s_addr_bus_strap;
	logic [1:0] s_half;
	logic [1:0] s_ft0;
	logic [1:0] s_ft1;

	reset_sync u_reset_sync ( // [R5]
		.i_ref_clk(i_ref_clk),
		.i_clk_en(i_clk_en),
		.i_raw_n(i_rst_n),
		.o_sync_n(rst_sync_n)
	);

	// pins from outside the clock domain, two flops each
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			s_addr_bus_strap <= 2'h3;
			s_half <= 2'h3;
			s_ft0 <= 2'h3;
			s_ft1 <= 2'h3;
		end else if (i_clk_en) begin
			s_addr_bus_strap <= {s_addr_bus_strap[0], i_addr_bus_strap};
			s_half <= {s_half[0], i_half_clock_strap};
			s_ft0 <= {s_ft0[0], i_float_test0_n};
			s_ft1 <= {s_ft1[0], i_float_test1_n};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state

	typedef struct packed {
		logic in_reset;
		logic [12:0] reset_cnt;
		logic straps_taken;
		logic addr_bus_strap_pending;
		logic addr_bus_strap;
		logic half;
		logic float_all;
		logic [2:0] fetch_cnt;
		logic fetch_start;
		logic [19:0] fetch_addr;
		logic div_ph;
		logic clk_out;
		bus_phase_t phase;
		logic [2:0] ctype;
		logic dma;
		logic rfsh;
		logic skip;
		logic hold;
		logic [2:0] cs;
		logic cs_oe_n;
		logic rd_n;
		logic rd_oe_n;
		logic addr_ph;
		logic ad_oe_n;
		logic rf_n;
		logic rf_oe_n;
		logic s6;
		logic s6_oe_n;
	} state_t;

	state_t r;
	state_t next_r;

	localparam state_t RESET_STATE = '{
		in_reset: 1'b1,
		reset_cnt: 13'h0,
		straps_taken: 1'b0,
		addr_bus_strap_pending: 1'b0,
		addr_bus_strap: 1'b1,
		half: 1'b0,
		float_all: 1'b0,
		fetch_cnt: 3'h0,
		fetch_start: 1'b0,
		fetch_addr: RESET_ADDR,
		div_ph: 1'b0,
		clk_out: 1'b0,
		phase: T_IDLE,
		ctype: CYC_PASSIVE,
		dma: 1'b0,
		rfsh: 1'b0,
		skip: 1'b0,
		hold: 1'b0,
		cs: CYC_PASSIVE,
		cs_oe_n: 1'b0,
		rd_n: 1'b1,
		rd_oe_n: 1'b0,
		addr_ph: 1'b0,
		ad_oe_n: 1'b1,
		rf_n: 1'b1,
		rf_oe_n: 1'b1,
		s6: 1'b0,
		s6_oe_n: 1'b1
	};

	localparam logic [12:0] FILTER_MAX = 13'(RESET_FILTER_CYC > 8191 ? 8191
		: RESET_FILTER_CYC);
	// two sync edges and the strap edge already count towards the delay
	localparam logic [2:0] FETCH_WAIT = 3'(FETCH_DELAY_CYC - 3);

	logic bus_float;

	always_comb begin
		next_r = r;
		next_r.fetch_start = 1'b0;
		// output clock toggles, or every other edge in half mode
		next_r.div_ph = ~r.div_ph;
		if (!r.half || r.div_ph) begin // [R16]
			next_r.clk_out = ~r.clk_out;
		end

		if (!rst_sync_n) begin
			// abandon everything but the latched straps, point at reset vector
			next_r = RESET_STATE; // [R3]
			next_r.addr_bus_strap = r.addr_bus_strap;
			next_r.half = r.half;
			next_r.float_all = r.float_all;
			next_r.clk_out = ~r.clk_out;
		end else if (r.in_reset) begin
			// rising reset edge: sample clock and test straps
			next_r.in_reset = 1'b0;
			next_r.half = ~s_half[1]; // [R16]
			next_r.float_all = ~s_ft0[1] & ~s_ft1[1]; // [R20]
			next_r.addr_bus_strap_pending = 1'b1;
			next_r.fetch_cnt = 3'h0;
		end else begin
			if (r.addr_bus_strap_pending) begin
				next_r.addr_bus_strap = s_addr_bus_strap[1]; // [R11]
				next_r.addr_bus_strap_pending = 1'b0;
				next_r.straps_taken = 1'b1; // [R19]
			end
			if (!r.straps_taken || r.fetch_cnt != FETCH_WAIT) begin
				if (r.fetch_cnt != FETCH_WAIT) begin
					next_r.fetch_cnt = r.fetch_cnt + 3'h1;
				end
				next_r.fetch_start = (r.fetch_cnt + 3'h1) == FETCH_WAIT; // [R7]
				next_r.fetch_addr = RESET_ADDR; // [R3]
			end
			next_r.reset_cnt = 13'h0;
			// bus hold only taken between cycles
			if (r.phase == T_IDLE) begin
				next_r.hold = i_hold_req;
			end
			case (r.phase)
				T_IDLE: begin
					if (i_cycle_start && !i_hold_req && r.fetch_cnt == FETCH_WAIT) begin
						next_r.phase = T_ADDR;
						next_r.ctype = i_cycle_type;
						next_r.dma = i_cycle_dma;
						next_r.rfsh = i_cycle_refresh;
						// skip bit honoured only with the strap high
						next_r.skip = r.addr_bus_strap & // [R9] [R10]
							((i_cycle_upper_sel & i_up_skip_addr_phase_bit) |
							(i_cycle_lower_sel & i_low_skip_addr_phase_bit));
					end
				end
				T_ADDR: next_r.phase = T_TURN;
				T_TURN: next_r.phase = T_DATA;
				T_DATA: next_r.phase = T_END;
				T_END: next_r.phase = T_IDLE;
				default: next_r.phase = T_IDLE;
			endcase
		end

		// pin outputs derived from the next phase
		bus_float = next_r.float_all;
		next_r.cs = (next_r.phase == T_IDLE || next_r.phase == T_END)
			? CYC_PASSIVE : next_r.ctype; // [R13]
		next_r.cs_oe_n = next_r.hold | bus_float; // [R14]
		next_r.addr_ph = next_r.phase == T_ADDR && !next_r.skip; // [R9]
		next_r.ad_oe_n = !next_r.addr_ph || next_r.hold || bus_float;
		// turnaround keeps strobe off while the bus is released
		next_r.rd_n = !(next_r.phase == T_DATA && // [R1]
			(next_r.ctype == CYC_MEM_RD || next_r.ctype == CYC_IO_RD ||
			next_r.ctype == CYC_FETCH));
		next_r.rd_oe_n = next_r.hold | bus_float; // [R2]
		// psram mode uses its own refresh select instead
		next_r.rf_n = !(next_r.rfsh && !i_psram_mode && // [R8]
			next_r.phase != T_IDLE);
		next_r.rf_oe_n = next_r.hold | bus_float | next_r.in_reset; // [R12]
		next_r.s6 = next_r.dma && (next_r.phase == T_TURN ||
			next_r.phase == T_DATA || next_r.phase == T_END); // [R15]
		next_r.s6_oe_n = next_r.hold | bus_float | next_r.in_reset; // [R15]
	end

	// stretch sync reset is not needed: source holds it 1 ms
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			r <= RESET_STATE; // [R3]
		end else if (i_clk_en) begin
			r <= next_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs, all straight from flops

	assign o_system_clock_out = r.clk_out;
	assign o_fetch_start = r.fetch_start;
	assign o_fetch_addr = r.fetch_addr;
	assign o_hold_ack = r.hold;
	assign o_cycle_status = r.cs;
	assign o_cycle_status_oe_n = r.cs_oe_n;
	assign o_read_strobe_n = r.rd_n;
	assign o_read_strobe_oe_n = r.rd_oe_n;
	assign o_mux_addr_phase = r.addr_ph;
	assign o_muxed_addr_data_oe_n = r.ad_oe_n;
	assign o_refresh_strobe_n = r.rf_n;
	assign o_refresh_strobe_oe_n = r.rf_oe_n;
	assign o_dma_cycle_flag = r.s6;
	assign o_dma_cycle_flag_oe_n = r.s6_oe_n;
	assign o_emulator_pins_normal = ~r.addr_bus_strap; // [R18]
	assign o_float_all_test_mode = r.float_all;
	assign o_half_clock_mode = r.half;
	assign o_addr_phase_enabled = r.addr_bus_strap;

endmodule

// ==== tb/bus_status_reset_properties.sv ====
`timescale 1ns/1ns
module bus_status_reset_properties
	import bus_status_pkg::*;
(
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic o_fetch_start,
	input wire logic [19:0] o_fetch_addr,
	input wire logic o_hold_ack,
	input wire logic [2:0] o_cycle_status,
	input wire logic o_cycle_status_oe_n,
	input wire logic o_read_strobe_n,
	input wire logic o_read_strobe_oe_n,
	input wire logic o_mux_addr_phase,
	input wire logic o_muxed_addr_data_oe_n,
	input wire logic o_refresh_strobe_oe_n,
	input wire logic o_dma_cycle_flag_oe_n,
	input wire logic o_float_all_test_mode,
	input wire logic o_addr_phase_enabled
);
default clocking cb @(posedge i_ref_clk); endclocking
default disable iff (!i_rst_n);
// first fetch window around the rounded release delay
localparam int FETCH_LO = FETCH_DELAY_CYC - 1;
localparam int FETCH_HI = FETCH_DELAY_CYC + 1;
////////////////////////////////////////////////////////////////////////
// first cycle of a driven status code
sequence s_start;
	!o_cycle_status_oe_n && o_cycle_status != CYC_PASSIVE
	&& $past(o_cycle_status) == CYC_PASSIVE;
endsequence
sequence s_body;
	$stable(o_cycle_status) [*2] ##1 o_cycle_status == CYC_PASSIVE;
endsequence
AST_STATUS_WALK: assert property (s_start |=> s_body)
	else $error("status walk broken");
AST_ADDR_FORCED: assert property (s_start ##0 !o_addr_phase_enabled
	|-> o_mux_addr_phase) else $error("address phase missing");
AST_RD_FLOATED: assert property ($fell(o_read_strobe_n)
	|-> o_muxed_addr_data_oe_n && $past(o_muxed_addr_data_oe_n))
	else $error("read strobe before bus float");
AST_RD_HOLD: assert property (o_hold_ack |-> o_read_strobe_oe_n)
	else $error("read strobe driven in hold");
AST_STATUS_HOLD: assert property (o_hold_ack |-> o_cycle_status_oe_n)
	else $error("status driven in hold");
AST_RFSH_FLOAT: assert property ((o_hold_ack || o_float_all_test_mode)
	|-> o_refresh_strobe_oe_n) else $error("refresh pin driven");
AST_DMA_HOLD: assert property (o_hold_ack |-> o_dma_cycle_flag_oe_n)
	else $error("dma flag driven in hold");
AST_FETCH_VEC: assert property (o_fetch_start
	|-> o_fetch_addr == RESET_ADDR && !$past(o_fetch_start))
	else $error("bad first fetch");
AST_STRAP_HELD: assert property (o_fetch_start
	|=> $stable(o_addr_phase_enabled) [*8]) else $error("strap moved");
AST_FETCH_TIME: assert property ($rose(i_rst_n)
	|-> ##[FETCH_LO:FETCH_HI] o_fetch_start)
	else $error("first fetch out of window");
AST_FLOAT_ALL: assert property (o_float_all_test_mode
	|-> o_cycle_status_oe_n && o_read_strobe_oe_n
	&& o_dma_cycle_flag_oe_n && o_muxed_addr_data_oe_n)
	else $error("pin driven in float test mode");
endmodule

bind bus_status_reset bus_status_reset_properties
	u_bus_status_reset_properties (.*);

// ==== tb/reset_source.sv ====
`timescale 1ns/1ns
module reset_source #(
	parameter int HOLD_CYC = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_go,
	output logic o_rst_n
);
	initial o_rst_n = 1'b0;
	// hold scaled down from 1 ms; release off the edge, as a pin would
	always @(posedge i_go) begin
		o_rst_n = 1'b0;
		repeat (HOLD_CYC) @(posedge i_ref_clk);
		#1 o_rst_n = 1'b1;
	end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/1ns
module testbench
	import bus_status_pkg::*;
;
logic i_ref_clk, i_rst_n, i_clk_en, i_addr_bus_strap, i_half_clock_strap;
logic i_float_test0_n, i_float_test1_n, i_hold_req, i_cycle_start;
logic i_cycle_dma, i_cycle_refresh, i_cycle_upper_sel, i_cycle_lower_sel;
logic i_psram_mode, i_up_skip_addr_phase_bit, i_low_skip_addr_phase_bit;
logic [2:0] i_cycle_type, o_cycle_status;
logic [19:0] o_fetch_addr;
logic o_system_clock_out, o_fetch_start, o_hold_ack, o_cycle_status_oe_n;
logic o_read_strobe_n, o_read_strobe_oe_n, o_mux_addr_phase;
logic o_muxed_addr_data_oe_n, o_refresh_strobe_n, o_refresh_strobe_oe_n;
logic o_dma_cycle_flag, o_dma_cycle_flag_oe_n, o_emulator_pins_normal;
logic o_float_all_test_mode, o_half_clock_mode, o_addr_phase_enabled;
logic go, addr_bus_strap;
int err_count, n_checks, cyc;
localparam int RST_HOLD = 8;
bus_status_reset #(.RESET_FILTER_CYC(8)) u_bus_status_reset (.*);
reset_source #(.HOLD_CYC(RST_HOLD)) u_reset_source (.i_ref_clk(i_ref_clk),
	.i_go(go), .o_rst_n(i_rst_n));
////////////////////////////////////////////////////////////////////////
task chk(input string nm, input logic [19:0] exp, got);
	n_checks++;
	if (got !== exp) begin
		err_count++;
		$display("BAD %s exp %h got %h", nm, exp, got);
	end
endtask
task conclude;
	if (err_count == 0 && n_checks > 0)
		$display("TEST PASSED");
	else
		$display("TEST FAILED");
	$finish;
endtask
task tick;
	@(posedge i_ref_clk) #1;
endtask
task t_reset(input logic a, h, f0, f1);
	int n;
	tick;
	{i_addr_bus_strap, i_half_clock_strap} = {a, h};
	{i_float_test0_n, i_float_test1_n, addr_bus_strap, go} = {f0, f1, a, 1'b1};
	tick;
	go = 0;
	n = 0;
	while (o_fetch_start !== 1'b1 && n < 40) begin
		tick;
		n++;
	end
	chk("fetch_wait", RST_HOLD - 1 + FETCH_DELAY_CYC, n);
	if (f0 | f1) begin
		chk("fetch", 1, o_fetch_start);
		chk("vector", RESET_ADDR, o_fetch_addr);
	end else begin
		chk("rfsh_oe", 1, o_refresh_strobe_oe_n);
		chk("st_float", 1, o_cycle_status_oe_n);
		chk("rd_float", 1, o_read_strobe_oe_n);
		chk("ad_float", 1, o_muxed_addr_data_oe_n);
	end
	chk("addr_bus_strap", a, o_addr_phase_enabled);
	chk("half", !h, o_half_clock_mode);
	chk("float", !(f0 | f1), o_float_all_test_mode);
	chk("emu", !a, o_emulator_pins_normal);
	// address and half clock strap pins wander after sampling; captured copies must not follow
	{i_addr_bus_strap, i_half_clock_strap} = {!a, !h};
	repeat (4) tick;
	chk("addr_bus_strap_kept", a, o_addr_phase_enabled);
	chk("half_kept", !h, o_half_clock_mode);
	{i_addr_bus_strap, i_half_clock_strap} = 2'h3;
endtask
task run_cyc(input logic [2:0] ty, input logic d, sk, rf);
	int n;
	logic seen;
	{i_cycle_type, i_cycle_dma, i_cycle_refresh} = {ty, d, rf};
	{i_up_skip_addr_phase_bit, i_cycle_start} = {sk, 1'b1};
	n = 0;
	while (o_cycle_status === CYC_PASSIVE && n < 8) begin
		tick;
		n++;
	end
	i_cycle_start = 0;
	chk("status", ty, o_cycle_status);
	chk("addr", !(addr_bus_strap && sk), o_mux_addr_phase);
	chk("ad_oe", addr_bus_strap && sk, o_muxed_addr_data_oe_n);
	seen = !o_refresh_strobe_n;
	tick;
	chk("dma", d, o_dma_cycle_flag);
	chk("rd_turn", 1, o_read_strobe_n);
	chk("ad_turn", 1, o_muxed_addr_data_oe_n);
	seen |= !o_refresh_strobe_n;
	tick;
	if (ty != CYC_INTA && ty != CYC_HALT)
		chk("rd", !(ty inside {CYC_IO_RD, CYC_FETCH, CYC_MEM_RD}),
			o_read_strobe_n);
	seen |= !o_refresh_strobe_n;
	tick;
	chk("passive", CYC_PASSIVE, o_cycle_status);
	chk("rfsh", rf && !i_psram_mode, seen);
	tick;
endtask
task t_hold;
	{i_hold_req, i_cycle_start} = 2'h3;
	repeat (4) tick;
	chk("hold_ack", 1, o_hold_ack);
	chk("st_oe", 1, o_cycle_status_oe_n);
	chk("rd_oe", 1, o_read_strobe_oe_n);
	chk("rf_oe", 1, o_refresh_strobe_oe_n);
	chk("dma_oe", 1, o_dma_cycle_flag_oe_n);
	{i_hold_req, i_cycle_start} = 2'h0;
	repeat (3) tick;
endtask
task t_abort;
	{i_cycle_type, i_cycle_dma, i_cycle_start} = {CYC_MEM_RD, 2'h3};
	repeat (3) tick;
	{i_cycle_start, go} = 2'h1;
	#2;
	chk("abort_st", CYC_PASSIVE, o_cycle_status);
	chk("abort_rd", 1, o_read_strobe_n);
	chk("abort_dma", 1, o_dma_cycle_flag_oe_n);
	go = 0;
	repeat (14) tick;
endtask
task t_clk(input logic half);
	int n;
	logic v;
	// count toggles, so a stuck clock cannot pass
	n = 0;
	repeat (4) begin
		v = o_system_clock_out;
		tick;
		n += (v != o_system_clock_out);
	end
	chk("clk_toggles", half ? 2 : 4, n);
endtask
////////////////////////////////////////////////////////////////////////
initial begin
	i_ref_clk = 0;
	forever #20 i_ref_clk = ~i_ref_clk;
end
always @(posedge i_ref_clk) begin
	cyc++;
	if (cyc > 3000) begin
		err_count++;
		conclude;
	end
end
initial begin
	{i_clk_en, i_cycle_upper_sel, i_cycle_lower_sel} = 3'h6;
	{i_low_skip_addr_phase_bit, i_psram_mode, i_hold_req} = 3'h0;
	{i_addr_bus_strap, i_half_clock_strap, i_float_test0_n} = 3'h7;
	{i_float_test1_n, i_cycle_start, i_cycle_dma, i_cycle_refresh} = 4'h8;
	{i_up_skip_addr_phase_bit, i_cycle_type, go, addr_bus_strap} = 6'h01;
	{err_count, n_checks, cyc} = 0;
	t_reset(1, 1, 1, 1);
	for (int t = 0; t < 7; t++)
		run_cyc(3'(t), t[0], 1'b1, 1'b0);
	run_cyc(CYC_MEM_RD, 0, 0, 1);
	i_psram_mode = 1;
	run_cyc(CYC_MEM_RD, 0, 0, 1);
	i_psram_mode = 0;
	t_clk(0);
	t_hold;
	t_abort;
	t_reset(0, 1, 1, 1);
	run_cyc(CYC_FETCH, 0, 1, 0);
	run_cyc(CYC_IO_WR, 1, 1, 0);
	t_reset(1, 0, 1, 1);
	t_clk(1);
	t_reset(1, 1, 0, 0);
	conclude;
end
endmodule
